// File: hdl/cco_ctrl.sv
// Summary of operation
// R1 - sixteen attribute registers, each for one 16-Mbyte external range
// R2 - all three caches hold a range only while its flag is set
// R3 - reset clears every range flag, external memory starts uncached
// R4 - on-chip level-2 sram is always cacheable
// R5 - setting a flag caches later accesses with no other procedure
// R6 - software empties caches of a range before clearing its flag
// R7 - global flush-discard pending flag reads 0 once finished
// R8 - each block count reads 0 once its operation finished
// R9 - with level-2 cache off, software uses data-cache block flush
// R10 - a block covers at most 65535 words, about 256 Kbyte
// R11 - registers 0-3 from 8000 0000h, 4-7 from 9000 0000h
// R12 - registers 8-11 from A000 0000h, 12-15 from B000 0000h
// R13 - one cache operation at a time; control writes stall meanwhile
// R14 - global writeback keeps level-2 valid, flushes held data lines
// R15 - global flush-discard invalidates level 2 and the program cache
// R16 - discard-all bits drop a whole level-1 cache, no writeback
// R17 - block writeback flushes data lines, keeps level-2 lines valid
// R18 - block flush-discard also invalidates level 2 and program cache
// R19 - program block discard touches only the program cache
// R20 - data block flush-discard hits both level-1 caches, not level 2
// R21 - level-2 operations reach level 1 only with level-2 cache on
// R22 - base written first; a non-zero count starts the operation
// R23 - global pending flag reads 1 until the operation completes
// R24 - base writes during an active operation stall until it ends
// R25 - addresses outside all ranges are uncached, upper bits decode
// R26 - globals stall accesses to their cache; blocks run behind
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module cco_ctrl #(
    parameter logic [31:0] SRAM_BASE = 32'h0000_0000,
    parameter logic [31:0] SRAM_BYTES = 32'h0001_0000
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // axi4-lite write
    input wire logic [cco_pkg::ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // axi4-lite read
    input wire logic [cco_pkg::ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // cacheability lookup
    input wire logic [31:0] lookup_addr_in,
    output logic cacheable_out,
    // command to cache arrays
    output logic cmd_valid_out,
    input wire logic cmd_ready_in,
    output logic [cco_pkg::EFF_W-1:0] cmd_effect_out,
    output logic [31:0] cmd_addr_out,
    output logic [cco_pkg::COUNT_W-1:0] cmd_words_out,
    input wire logic op_done_in,
    // access stalls and mode
    output logic pcache_stall_out,
    output logic dcache_stall_out,
    output logic l2_stall_out,
    output logic [cco_pkg::MODE_W-1:0] l2_mode_out
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT
    } cco_fsm_e;

    typedef struct packed {
        logic aw_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [cco_pkg::NUM_RANGES-1:0] attr;
        logic [cco_pkg::MODE_W-1:0] mode;
        logic gwb_pend;
        logic gflush_pend;
        logic pdis_pend;
        logic ddis_pend;
        logic [31:0] blk_base;
        logic [cco_pkg::COUNT_W-1:0] blk_count;
        logic [1:0] blk_sel;
        cco_pkg::cco_op_e op;
        cco_fsm_e fsm;
        logic cmd_valid;
        logic [cco_pkg::EFF_W-1:0] cmd_eff;
        logic pc_stall;
        logic dc_stall;
        logic l2_stall;
        logic cacheable;
    } cco_state_s;

    cco_state_s st;
    cco_state_s next_st;
    logic dec_cacheable;
    logic dec_in_range;
    logic [3:0] dec_index;
    logic busy;
    logic wr_fire;
    logic rd_fire;
    logic finish;

    // ****************************************************
    // helpers
    // ****************************************************
    // read value and hit flag of one register
    function automatic logic [32:0] rd_val(
        input cco_state_s s,
        input logic [cco_pkg::ADDR_W-1:0] a
    );
        logic [31:0] d;
        logic hit;
        d = 32'h0000_0000;
        hit = 1'b1;
        if (a < cco_pkg::OFS_GWB)
            d[cco_pkg::CACHEABLE_BIT] = s.attr[a[5:2]];
        else
        begin
            unique case (a)
                cco_pkg::OFS_GWB: d[cco_pkg::PEND_BIT] = s.gwb_pend;
                cco_pkg::OFS_GFLUSH: d[cco_pkg::PEND_BIT] = s.gflush_pend;
                cco_pkg::OFS_CONFIG:
                begin
                    d[cco_pkg::MODE_LSB +: cco_pkg::MODE_W] = s.mode;
                    d[cco_pkg::PDIS_BIT] = s.pdis_pend;
                    d[cco_pkg::DDIS_BIT] = s.ddis_pend;
                end
                cco_pkg::OFS_LEVEL2_GLOBAL_WRITEBACK_REG_BASE, cco_pkg::OFS_L2FD_BASE,
                cco_pkg::OFS_PBLK_BASE, cco_pkg::OFS_DBLK_BASE:
                    d = s.blk_base;
                cco_pkg::OFS_LEVEL2_GLOBAL_WRITEBACK_REG_COUNT, cco_pkg::OFS_L2FD_COUNT,
                cco_pkg::OFS_PBLK_COUNT, cco_pkg::OFS_DBLK_COUNT:
                    if (s.blk_sel == a[4:3])
                        d[cco_pkg::COUNT_W-1:0] = s.blk_count;
                default: hit = 1'b0;
            endcase
        end
        return {hit, d};
    endfunction

    // effect mask of an operation, given level-2 cache enabled
    function automatic logic [cco_pkg::EFF_W-1:0] effects(
        input cco_pkg::cco_op_e op,
        input logic l2en
    );
        logic [cco_pkg::EFF_W-1:0] e;
        e = '0;
        unique case (op)
            // R14 level-2 writeback, held data lines flushed
            cco_pkg::OP_GWB:
                e = l2en ? 7'h6E : 7'h00;
            // R15 adds level-2 and whole program cache invalidate
            cco_pkg::OP_GFLUSH:
                e = l2en ? 7'h7F : 7'h00;
            // R16 whole level-1 discard, no writeback
            cco_pkg::OP_PDIS: e = 7'h41;
            cco_pkg::OP_DDIS: e = 7'h44;
            // R17 block writeback keeps level-2 lines valid
            cco_pkg::OP_BWB: e = l2en ? 7'h2E : 7'h00;
            // R18 block flush-discard also invalidates program lines
            cco_pkg::OP_BFLUSH: e = l2en ? 7'h3F : 7'h00;
            // R19 program cache only
            cco_pkg::OP_PBLK: e = 7'h01;
            // R20 both level-1 caches, level 2 untouched
            cco_pkg::OP_DBLK: e = 7'h07;
        endcase
        return e;
    endfunction

    // ****************************************************
    // range decode
    // ****************************************************
    cco_range_decode #(
        .SRAM_BASE(SRAM_BASE),
        .SRAM_BYTES(SRAM_BYTES)
    ) u_decode (
        .addr_in(lookup_addr_in),
        .attr_in(st.attr),
        .in_range_out(dec_in_range),
        .index_out(dec_index),
        .cacheable_out(dec_cacheable)
    );

    assign busy = (st.fsm != ST_IDLE);
    assign wr_fire = awvalid_in && st.aw_rdy;
    assign rd_fire = arvalid_in && st.ar_rdy;
    assign finish = (st.fsm == ST_WAIT) && op_done_in;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        logic [32:0] rv;
        logic [31:0] m;
        logic [31:0] wv;
        logic start;
        logic l2en;
        cco_pkg::cco_op_e kind;
        next_st = st;
        rv = rd_val(st, awaddr_in);
        m = {{8{wstrb_in[3]}}, {8{wstrb_in[2]}},
            {8{wstrb_in[1]}}, {8{wstrb_in[0]}}};
        wv = (rv[31:0] & ~m) | (wdata_in & m);
        start = 1'b0;
        kind = cco_pkg::OP_GWB;
        l2en = (st.mode != cco_pkg::MODE_ALL_SRAM);
        next_st.cacheable = dec_cacheable;
        next_st.aw_rdy = 1'b0;
        next_st.ar_rdy = 1'b0;
        if (st.bvalid && bready_in)
            next_st.bvalid = 1'b0;
        if (st.rvalid && rready_in)
            next_st.rvalid = 1'b0;
        // R13 control writes wait while an operation runs
        // R24 base writes included
        if (!st.aw_rdy && !st.bvalid && awvalid_in && wvalid_in
            && !(busy && awaddr_in >= cco_pkg::OFS_GWB))
            next_st.aw_rdy = 1'b1;
        if (wr_fire)
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp = rv[32] ? cco_pkg::RESP_OKAY
                : cco_pkg::RESP_SLVERR;
            // R1 one flag per 16-Mbyte range
            // R5 takes effect on the next lookup
            if (awaddr_in < cco_pkg::OFS_GWB)
                next_st.attr[awaddr_in[5:2]] = wv[cco_pkg::CACHEABLE_BIT];
            else
            begin
                unique case (awaddr_in)
                    cco_pkg::OFS_GWB:
                    begin
                        start = wv[cco_pkg::PEND_BIT];
                        kind = cco_pkg::OP_GWB;
                    end
                    cco_pkg::OFS_GFLUSH:
                    begin
                        start = wv[cco_pkg::PEND_BIT];
                        kind = cco_pkg::OP_GFLUSH;
                    end
                    cco_pkg::OFS_CONFIG:
                    begin
                        next_st.mode = wv[cco_pkg::MODE_LSB +: cco_pkg::MODE_W];
                        start = wv[cco_pkg::PDIS_BIT] || wv[cco_pkg::DDIS_BIT];
                        kind = wv[cco_pkg::PDIS_BIT] ? cco_pkg::OP_PDIS
                            : cco_pkg::OP_DDIS;
                    end
                    cco_pkg::OFS_LEVEL2_GLOBAL_WRITEBACK_REG_BASE, cco_pkg::OFS_L2FD_BASE,
                    cco_pkg::OFS_PBLK_BASE, cco_pkg::OFS_DBLK_BASE:
                        next_st.blk_base = {wv[31:2], 2'h0};
                    // R22 non-zero count starts the block
                    // R10 count is 16 bits wide
                    cco_pkg::OFS_LEVEL2_GLOBAL_WRITEBACK_REG_COUNT, cco_pkg::OFS_L2FD_COUNT,
                    cco_pkg::OFS_PBLK_COUNT, cco_pkg::OFS_DBLK_COUNT:
                    begin
                        start = (wv[cco_pkg::COUNT_W-1:0] != '0);
                        // count offsets 54h/5Ch/64h/6Ch map to ops 4..7
                        kind = cco_pkg::cco_op_e'({1'b1, ~awaddr_in[4],
                            awaddr_in[3]});
                        next_st.blk_count = wv[cco_pkg::COUNT_W-1:0];
                        next_st.blk_sel = awaddr_in[4:3];
                    end
                    default: ;
                endcase
            end
        end
        // R21 level-2 operations do nothing in all-sram mode
        if (start && effects(kind, l2en) != '0)
        begin
            next_st.op = kind;
            next_st.fsm = ST_ISSUE;
            next_st.cmd_valid = 1'b1;
            next_st.cmd_eff = effects(kind, l2en);
            next_st.gwb_pend = (kind == cco_pkg::OP_GWB);
            next_st.gflush_pend = (kind == cco_pkg::OP_GFLUSH);
            next_st.pdis_pend = (kind == cco_pkg::OP_PDIS);
            next_st.ddis_pend = (kind == cco_pkg::OP_DDIS);
            // R26 only globals stall their cache
            if (next_st.cmd_eff[cco_pkg::EFF_GLOBAL])
            begin
                next_st.pc_stall = next_st.cmd_eff[cco_pkg::EFF_L1P_INV];
                next_st.dc_stall = next_st.cmd_eff[cco_pkg::EFF_L1D_INV];
                next_st.l2_stall = next_st.cmd_eff[cco_pkg::EFF_L2_WB];
            end
        end
        else if (start)
            next_st.blk_count = '0;
        unique case (st.fsm)
            ST_IDLE: ;
            ST_ISSUE:
                if (cmd_ready_in)
                begin
                    next_st.cmd_valid = 1'b0;
                    next_st.fsm = ST_WAIT;
                end
            ST_WAIT:
                if (op_done_in)
                begin
                    next_st.fsm = ST_IDLE;
                    // R7 R23 pending flags drop at completion
                    next_st.gwb_pend = 1'b0;
                    next_st.gflush_pend = 1'b0;
                    next_st.pdis_pend = 1'b0;
                    next_st.ddis_pend = 1'b0;
                    // R8 count reads zero when done
                    next_st.blk_count = '0;
                    next_st.pc_stall = 1'b0;
                    next_st.dc_stall = 1'b0;
                    next_st.l2_stall = 1'b0;
                end
        endcase
        if (!st.ar_rdy && !st.rvalid && arvalid_in)
            next_st.ar_rdy = 1'b1;
        if (rd_fire)
        begin
            rv = rd_val(st, araddr_in);
            next_st.rvalid = 1'b1;
            next_st.rdata = rv[31:0];
            next_st.rresp = rv[32] ? cco_pkg::RESP_OKAY
                : cco_pkg::RESP_SLVERR;
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st <= '0;
            // R3 all ranges uncached
            st.attr <= cco_pkg::ATTR_RESET;
            st.mode <= cco_pkg::MODE_ALL_SRAM;
            st.fsm <= ST_IDLE;
            st.op <= cco_pkg::OP_GWB;
        end
        else
            st <= next_st;
    end

    assign awready_out = st.aw_rdy;
    assign wready_out = st.aw_rdy;
    assign bvalid_out = st.bvalid;
    assign bresp_out = st.bresp;
    assign arready_out = st.ar_rdy;
    assign rvalid_out = st.rvalid;
    assign rdata_out = st.rdata;
    assign rresp_out = st.rresp;
    assign cacheable_out = st.cacheable;
    assign cmd_valid_out = st.cmd_valid;
    assign cmd_effect_out = st.cmd_eff;
    assign cmd_addr_out = st.blk_base;
    assign cmd_words_out = st.blk_count;
    assign pcache_stall_out = st.pc_stall;
    assign dcache_stall_out = st.dc_stall;
    assign l2_stall_out = st.l2_stall;
    assign l2_mode_out = st.mode;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_finish;
        st.fsm == ST_WAIT && op_done_in;
    endsequence

    sequence s_gwb_start;
        wr_fire && awaddr_in == cco_pkg::OFS_GWB
            && wdata_in[cco_pkg::PEND_BIT] && wstrb_in[0]
            && st.mode != cco_pkg::MODE_ALL_SRAM;
    endsequence

    a_range_gated: assert property ( // R2
        dec_in_range && !st.attr[dec_index]
            && !(lookup_addr_in >= SRAM_BASE
            && (lookup_addr_in - SRAM_BASE) < SRAM_BYTES)
            |=> !cacheable_out)
        else $error("uncached range reported cacheable");
    a_range_set: assert property ( // R5
        dec_in_range && st.attr[dec_index] |=> cacheable_out)
        else $error("enabled range not cacheable");
    a_sram_always: assert property ( // R4
        lookup_addr_in == SRAM_BASE |=> cacheable_out)
        else $error("on-chip sram not cacheable");
    a_gwb_pending: assert property ( // R23
        s_gwb_start |=> st.gwb_pend ##1 (st.gwb_pend [*2]))
        else $error("global pending dropped early");
    a_pend_clear: assert property ( // R7
        s_finish |=> !st.gwb_pend && !st.gflush_pend)
        else $error("pending flag stuck after completion");
    a_count_clear: assert property ( // R8
        s_finish |=> st.blk_count == '0 && !busy)
        else $error("count not cleared on completion");
    a_single_op: assert property ( // R13
        busy && st.aw_rdy |-> awaddr_in < cco_pkg::OFS_GWB)
        else $error("control write taken during operation");
    a_cmd_hold: assert property ( // R22
        cmd_valid_out && !cmd_ready_in
            |=> cmd_valid_out && $stable(cmd_addr_out))
        else $error("command dropped before taken");
    a_l2_gate: assert property ( // R21
        cmd_valid_out && st.mode == cco_pkg::MODE_ALL_SRAM
            |-> !cmd_effect_out[cco_pkg::EFF_L2_HELD])
        else $error("level-2 operation in all-sram mode");
    a_global_stall: assert property ( // R26
        busy && st.cmd_eff[cco_pkg::EFF_GLOBAL]
            |-> pcache_stall_out || dcache_stall_out || l2_stall_out)
        else $error("global operation without stall");

endmodule

// File: shared/cco_pkg.sv
package cco_pkg;

    // ****************************************************
    // register map (byte addresses)
    // ****************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_ATTR0 = 8'h00;
    localparam logic [7:0] OFS_GWB = 8'h40;
    localparam logic [7:0] OFS_GFLUSH = 8'h44;
    localparam logic [7:0] OFS_CONFIG = 8'h48;
    localparam logic [7:0] OFS_LEVEL2_GLOBAL_WRITEBACK_REG_BASE = 8'h50;
    localparam logic [7:0] OFS_LEVEL2_GLOBAL_WRITEBACK_REG_COUNT = 8'h54;
    localparam logic [7:0] OFS_L2FD_BASE = 8'h58;
    localparam logic [7:0] OFS_L2FD_COUNT = 8'h5C;
    localparam logic [7:0] OFS_PBLK_BASE = 8'h60;
    localparam logic [7:0] OFS_PBLK_COUNT = 8'h64;
    localparam logic [7:0] OFS_DBLK_BASE = 8'h68;
    localparam logic [7:0] OFS_DBLK_COUNT = 8'h6C;

    // ****************************************************
    // fields and reset values
    // ****************************************************
    localparam int NUM_RANGES = 16;
    localparam int CACHEABLE_BIT = 0;
    localparam int PEND_BIT = 0;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int PDIS_BIT = 8;
    localparam int DDIS_BIT = 9;
    localparam int COUNT_W = 16;
    localparam logic [MODE_W-1:0] MODE_ALL_SRAM = 3'h0;
    localparam logic [NUM_RANGES-1:0] ATTR_RESET = 16'h0000;

    // ****************************************************
    // external range decode
    // ****************************************************
    localparam logic [31:0] RANGE_BYTES = 32'h0100_0000;
    localparam logic [1:0] GROUP_TAG = 2'h2;
    localparam logic [1:0] GROUP_SUB = 2'h0;

    // ****************************************************
    // operation effects on the cache arrays
    // ****************************************************
    localparam int EFF_W = 7;
    localparam int EFF_L1P_INV = 0;
    localparam int EFF_L1D_WB = 1;
    localparam int EFF_L1D_INV = 2;
    localparam int EFF_L2_WB = 3;
    localparam int EFF_L2_INV = 4;
    localparam int EFF_L2_HELD = 5;
    localparam int EFF_GLOBAL = 6;

    typedef enum logic [2:0] {
        OP_GWB,
        OP_GFLUSH,
        OP_PDIS,
        OP_DDIS,
        OP_BWB,
        OP_BFLUSH,
        OP_PBLK,
        OP_DBLK
    } cco_op_e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hdl/cco_range_decode.sv
module cco_range_decode #(
    parameter logic [31:0] SRAM_BASE = 32'h0000_0000,
    parameter logic [31:0] SRAM_BYTES = 32'h0001_0000
) (
    // lookup
    input wire logic [31:0] addr_in,
    input wire logic [cco_pkg::NUM_RANGES-1:0] attr_in,
    // answer
    output logic in_range_out,
    output logic [3:0] index_out,
    output logic cacheable_out
);

    logic in_sram;

    // ****************************************************
    // range select from upper address bits
    // ****************************************************
    always_comb
    begin
        // R11 four ranges above each 8, 9, A, B nibble
        // R12 index from nibble and sub-range bits
        index_out = {addr_in[29:28], addr_in[25:24]};
        // R25 anything outside the sixteen ranges and the on-chip sram is uncached
        in_range_out = (addr_in[31:30] == cco_pkg::GROUP_TAG)
            && (addr_in[27:26] == cco_pkg::GROUP_SUB);
        // R4 on-chip sram always cacheable
        in_sram = (addr_in >= SRAM_BASE)
            && ((addr_in - SRAM_BASE) < SRAM_BYTES);
        // R2 cacheable only while the range flag is set
        cacheable_out = in_sram || (in_range_out && attr_in[index_out]);
    end

endmodule

// File: dv/cco_array_model.sv
module cco_array_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // command handshake
    input wire logic cmd_valid_in,
    input wire logic [7:0] lat_in,
    output logic cmd_ready_out,
    output logic op_done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy;
    logic [7:0] cnt;
    // takes a command, then works lat_in+1 cycles before the done pulse
    always_ff @(posedge clk_in or negedge resetn_in)
        if (!resetn_in)
        begin
            busy <= 1'b0;
            cnt <= 8'h00;
            cmd_ready_out <= 1'b0;
            op_done_out <= 1'b0;
        end
        else
        begin
            cmd_ready_out <= 1'b0;
            op_done_out <= 1'b0;
            if (cmd_valid_in && cmd_ready_out)
            begin
                busy <= 1'b1;
                cnt <= lat_in;
            end
            else if (cmd_valid_in && !busy)
                cmd_ready_out <= 1'b1;
            else if (busy && cnt == 8'h00)
            begin
                busy <= 1'b0;
                op_done_out <= 1'b1;
            end
            else if (busy)
                cnt <= cnt - 8'h01;
        end
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, done_seen = 1'b0;
    logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00, lat = 8'h10;
    logic [31:0] wdata_in = 32'h0, lookup_addr_in = 32'h0, d, a;
    logic [3:0] wstrb_in = 4'hF;
    logic [1:0] bresp_out, rresp_out, r;
    logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
    logic arvalid_in = 1'b0, rready_in = 1'b0;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic cacheable_out, cmd_valid_out, cmd_ready_in, op_done_in;
    logic pst, dst, lst;
    logic [31:0] rdata_out, cmd_addr_out;
    logic [6:0] cmd_effect_out;
    logic [15:0] cmd_words_out;
    logic [2:0] l2_mode_out;
    int fails = 0, num_checks = 0;
    localparam logic [7:0] BOFS [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h50, 8'h58, 8'h60, 8'h68};
    localparam logic [7:0] SOFS [8] = '{8'h40, 8'h44, 8'h48, 8'h48,
        8'h54, 8'h5C, 8'h64, 8'h6C};
    localparam logic [31:0] SDAT [8] = '{32'h1, 32'h1, 32'h101, 32'h201,
        32'hFFFF, 32'h10, 32'h1, 32'h20};
    localparam logic [6:0] EFF [8] = '{7'h6E, 7'h7F, 7'h41, 7'h44,
        7'h2E, 7'h3F, 7'h01, 7'h07};
    localparam logic [31:0] FIN [8] = '{32'h0, 32'h0, 32'h1, 32'h1,
        32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [2:0] STL [8] = '{3'h3, 3'h7, 3'h4, 3'h2,
        3'h0, 3'h0, 3'h0, 3'h0};

    cco_ctrl i_cco_ctrl (.ref_clk_in, .resetn_in, .awaddr_in, .awvalid_in,
        .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out,
        .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
        .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
        .lookup_addr_in, .cacheable_out, .cmd_valid_out, .cmd_ready_in,
        .cmd_effect_out, .cmd_addr_out, .cmd_words_out, .op_done_in,
        .pcache_stall_out(pst), .dcache_stall_out(dst), .l2_stall_out(lst),
        .l2_mode_out);
    cco_array_model i_cco_array_model (.clk_in(ref_clk_in), .resetn_in,
        .cmd_valid_in(cmd_valid_out), .lat_in(lat),
        .cmd_ready_out(cmd_ready_in), .op_done_out(op_done_in));

    always #25 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in)
        if (op_done_in === 1'b1)
            done_seen <= 1'b1;
        else if (cmd_valid_out === 1'b1)
            done_seen <= 1'b0;

    // ****************************************************
    // bus tasks
    // ****************************************************
    task automatic stop_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h seen %h", w, e, s);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 500)
        begin
            fails++;
            stop_test();
        end
        @(negedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        int n = 0;
        @(posedge ref_clk_in);
        awaddr_in <= ad;
        wdata_in <= dt;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        guard(n);
        while (awready_out !== 1'b1) guard(n);
        @(posedge ref_clk_in);
        awvalid_in <= 1'b0;
        wvalid_in <= 1'b0;
        guard(n);
        while (bvalid_out !== 1'b1) guard(n);
        r = bresp_out;
        @(posedge ref_clk_in);
        bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        int n = 0;
        @(posedge ref_clk_in);
        araddr_in <= ad;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        guard(n);
        while (arready_out !== 1'b1) guard(n);
        @(posedge ref_clk_in);
        arvalid_in <= 1'b0;
        guard(n);
        while (rvalid_out !== 1'b1) guard(n);
        d = rdata_out;
        r = rresp_out;
        @(posedge ref_clk_in);
        rready_in <= 1'b0;
    endtask
    task automatic look(input logic [31:0] ad, input logic e);
        @(posedge ref_clk_in);
        lookup_addr_in <= ad;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("cacheable", {31'h0, cacheable_out}, {31'h0, e});
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial
    begin
        int n;
        repeat (16) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rd(8'(4 * i));
            chk("attr reset", d, 32'h0);
        end
        look(32'h8000_0000, 1'b0);
        look(32'h0000_0100, 1'b1);
        look(32'h8400_0000, 1'b0);
        look(32'hC000_0000, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            a = 32'h8000_0000 | (32'(i / 4) << 28) | (32'(i % 4) << 24);
            wr(8'(4 * i), 32'h1);
            rd(8'(4 * i));
            chk("attr", d, 32'h1);
            look(a + 32'h00FF_FFFC, 1'b1);
            look(a ^ 32'h0100_0000, 1'b0);
            wr(8'(4 * i), 32'h0);
            look(a, 1'b0);
        end
        wr(8'hF0, 32'h1);
        chk("wr resp", {30'h0, r}, {30'h0, cco_pkg::RESP_SLVERR});
        rd(8'hF0);
        chk("rd resp", {30'h0, r}, {30'h0, cco_pkg::RESP_SLVERR});
        wr(8'h48, 32'h1);
        chk("mode", {29'h0, l2_mode_out}, 32'h1);
        wr(8'h64, 32'h0);
        repeat (3) @(negedge ref_clk_in);
        chk("zero count", {31'h0, cmd_valid_out}, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            lat = 8'(16 + 6 * k);
            if (BOFS[k] != 8'h00)
                wr(BOFS[k], 32'h0002_0040);
            wr(SOFS[k], SDAT[k]);
            n = 0;
            while (cmd_valid_out !== 1'b1) guard(n);
            chk("effect", {25'h0, cmd_effect_out}, {25'h0, EFF[k]});
            chk("stalls", {29'h0, pst, dst, lst}, {29'h0, STL[k]});
            if (BOFS[k] != 8'h00)
            begin
                chk("addr", cmd_addr_out, 32'h0002_0040);
                chk("words", {16'h0, cmd_words_out}, SDAT[k] & 32'hFFFF);
            end
            rd(SOFS[k]);
            chk("busy", {31'h0, d != 32'h0}, 32'h1);
            wr(8'h50, 32'h0);
            chk("stall", {31'h0, done_seen}, 32'h1);
            rd(SOFS[k]);
            chk("idle", d, FIN[k]);
            chk("unstall", {29'h0, pst, dst, lst}, 32'h0);
        end
        wr(8'h48, 32'h0);
        wr(8'h5C, 32'h10);
        chk("l2 off", {31'h0, cmd_valid_out}, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h68, 32'h8000_0000);
        wr(8'h6C, 32'h10);
        n = 0;
        do
        begin
            guard(n);
            rd(8'h6C);
        end
        while (d != 32'h0);
        wr(8'h00, 32'h0);
        look(32'h8000_0000, 1'b0);
        stop_test();
    end
endmodule
